/* src/dma_engine_control_registers.v */
// Six-channel DMA register block with APB slave, arbiter and transfer sequencer
`timescale 1ns/1ns
`default_nettype none
`include "dma_consts.vh"
module dma_engine_control_registers (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Hardware triggers, one pulse per request
	input  wire [5:0]  hw_trigger,
	// Data space master
	output reg         mem_req,
	output reg         mem_we,
	output reg         mem_byte,
	output reg  [15:0] mem_addr,
	output reg  [15:0] mem_wdata,
	input  wire        mem_ack,
	input  wire [15:0] mem_rdata
);
	localparam S_IDLE = 3'h0;
	localparam S_LOAD = 3'h1;
	localparam S_RD   = 3'h2;
	localparam S_WR   = 3'h3;
	localparam S_NW   = 3'h4;
	localparam S_NEXT = 3'h5;

	// Module registers
	reg         engine_enable;
	reg         priority_scheme_select;
	reg  [15:0] upper_limit_reg;
	reg  [15:0] lower_limit_reg;
	reg  [15:0] transfer_buffer_reg;

	// Sequencer
	reg  [2:0]  state;
	reg  [2:0]  act;
	reg  [2:0]  last_grant;
	wire        go;
	wire        adv;
	wire        fin;
	wire        last;

	// Per-channel views
	wire [6*`CH_CTRL_W-1:0] ctl_v;
	wire [5:0]  irq_v;
	wire [95:0] src_v;
	wire [95:0] dst_v;
	wire [95:0] cnt_v;
	wire [5:0]  req_v;
	wire [`CH_CTRL_W-1:0] cur_ctl;
	wire [15:0] cur_src;
	wire [15:0] cur_dst;
	wire [15:0] cur_cnt;

	// Bus decode
	wire [2:0]  blk;
	wire [2:0]  rsel;
	wire [2:0]  ch_sel;
	wire        mod_hit;
	wire        ch_hit;
	wire        wr_en;
	reg  [15:0] rd_val;

	// Buffer
	wire        f_in_ready;
	wire        f_out_valid;
	wire [15:0] f_out_data;
	wire        f_push;
	wire        f_pop;

	assign blk     = paddr[7:5];
	assign rsel    = paddr[4:2];
	assign ch_sel  = blk - 3'h1;
	assign mod_hit = (blk == 3'h0) && (rsel < `MOD_REGS);	// [R03]
	assign ch_hit  = (blk != 3'h0) && (blk <= 3'h6) && (rsel < `CH_REGS);	// [R04]
	assign wr_en   = psel & penable & pwrite & pready & (mod_hit | ch_hit);

	assign cur_ctl = ctl_v[act*`CH_CTRL_W +: `CH_CTRL_W];
	assign cur_src = src_v[act*16 +: 16];
	assign cur_dst = dst_v[act*16 +: 16];
	assign cur_cnt = cnt_v[act*16 +: 16];
	assign go      = (state == S_LOAD);
	assign adv     = (state == S_NEXT);
	assign last    = (cur_cnt <= 16'h0001);
	assign fin     = adv & (last | ~cur_ctl[`CH_TRCONT_BIT]);

	assign f_push  = (state == S_RD) & mem_req & mem_ack;
	assign f_pop   = (state == S_WR) & mem_req & mem_ack;

	// Arbiter: fixed starts at channel 0, round-robin just past the last grant
	function [2:0] pick;
		input [5:0] r;
		input [2:0] base;
		input       rr;
		integer     k;
		integer     j;
		reg         found;
		begin
			pick  = 3'h0;
			found = 1'b0;
			for (k = 0; k < 6; k = k + 1) begin
				j = rr ? (base + 1 + k) : k;
				if (j >= 6)
					j = j - 6;
				if (!found && r[j]) begin
					pick  = j[2:0];
					found = 1'b1;
				end
			end
		end
	endfunction

	word_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH),
		.AW    (`FIFO_AW)
	) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.flush     (~engine_enable),
		.in_valid  (f_push),
		.in_ready  (f_in_ready),
		.in_data   (mem_rdata),
		.out_valid (f_out_valid),
		.out_ready (f_pop),
		.out_data  (f_out_data)
	);

	genvar i;
	generate
		for (i = 0; i < `NUM_CH; i = i + 1) begin : g_ch
			reg  [`CH_CTRL_W-1:0] ctl;
			reg         irq_done;
			reg         pend;
			reg  [15:0] src;
			reg  [15:0] dst;
			reg  [15:0] cnt;
			reg  [15:0] src_sh;
			reg  [15:0] dst_sh;
			reg  [15:0] cnt_sh;
			wire        me;
			wire        wr_c;
			wire [15:0] step;
			wire [1:0]  sm;
			wire [1:0]  dm;

			assign me   = (act == i) && (state != S_IDLE);
			assign wr_c = wr_en && ch_hit && (ch_sel == i);
			assign step = ctl[`CH_SIZE_BIT] ? `STEP_BYTE : `STEP_WORD;
			assign sm   = ctl[`CH_SMODE_HI:`CH_SMODE_LO];
			assign dm   = ctl[`CH_DMODE_HI:`CH_DMODE_LO];
			assign ctl_v[i*`CH_CTRL_W +: `CH_CTRL_W] = ctl;
			assign irq_v[i]        = irq_done;
			assign src_v[i*16 +: 16] = src;
			assign dst_v[i*16 +: 16] = dst;
			assign cnt_v[i*16 +: 16] = cnt;
			assign req_v[i] = ctl[`CH_EN_BIT] & (pend | ctl[`CH_SREQ_BIT]);	// [R10]

			always @(posedge mclk) begin
				if (!rst_n) begin
					ctl      <= `CH_CTRL_RST;	// [R11]
					irq_done <= 1'b0;
					pend     <= 1'b0;
					src      <= 16'h0000;
					dst      <= 16'h0000;
					cnt      <= 16'h0000;
					src_sh   <= 16'h0000;
					dst_sh   <= 16'h0000;
					cnt_sh   <= 16'h0000;
				end else begin
					if (go && me)
						pend <= 1'b0;
					if (hw_trigger[i] && ctl[`CH_EN_BIT])
						pend <= 1'b1;
					if (go && me && ctl[`CH_RELOAD_BIT]) begin
						src <= src_sh;	// [R09]
						dst <= dst_sh;
						cnt <= cnt_sh;
					end
					if (adv && me) begin
						if (sm == `AM_INC)
							src <= src + step;	// [R07]
						else if (sm == `AM_DEC)
							src <= src - step;
						if (dm == `AM_INC)
							dst <= dst + step;	// [R08]
						else if (dm == `AM_DEC)
							dst <= dst - step;
						cnt <= cnt - 16'h0001;
					end
					if (fin && me) begin
						ctl[`CH_SREQ_BIT] <= 1'b0;	// [R10]
						if (last) begin
							irq_done <= 1'b1;
							if (ctl[`CH_TRREP_BIT]) begin
								src <= src_sh;
								dst <= dst_sh;
								cnt <= cnt_sh;
							end else begin
								ctl[`CH_EN_BIT] <= 1'b0;
							end
						end
					end
					// Software writes land last, so a new request beats the clear
					if (wr_c && rsel == `OFS_CH_CTRL)
						ctl <= pwdata[`CH_CTRL_W-1:0];	// [R11]
					if (wr_c && rsel == `OFS_CH_IRQ && pwdata[0] && !(fin && me && last))
						irq_done <= 1'b0;
					if (wr_c && rsel == `OFS_CH_SRC) begin
						src    <= pwdata[15:0];
						src_sh <= pwdata[15:0];
					end
					if (wr_c && rsel == `OFS_CH_DST) begin
						dst    <= pwdata[15:0];
						dst_sh <= pwdata[15:0];
					end
					if (wr_c && rsel == `OFS_CH_CNT) begin
						cnt    <= pwdata[15:0];
						cnt_sh <= pwdata[15:0];
					end
				end
			end
		end
	endgenerate

	// Module register writes
	always @(posedge mclk) begin
		if (!rst_n) begin
			engine_enable          <= 1'b0;	// [R06]
			priority_scheme_select <= 1'b0;	// [R06]
			upper_limit_reg        <= 16'h0000;
			lower_limit_reg        <= 16'h0000;
		end else if (wr_en && mod_hit) begin
			case (rsel)
				`OFS_ENG_CTRL: begin
					engine_enable          <= pwdata[`ENG_EN_BIT];	// [R01]
					priority_scheme_select <= pwdata[`ENG_RR_BIT];	// [R02]
				end
				`OFS_UPPER: upper_limit_reg <= pwdata[15:0];
				`OFS_LOWER: lower_limit_reg <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// Read mux; unused bits of engine control read as zero
	always @* begin
		rd_val = 16'h0000;
		if (mod_hit) begin
			case (rsel)
				`OFS_ENG_CTRL: begin
					rd_val[`ENG_EN_BIT] = engine_enable;	// [R05]
					rd_val[`ENG_RR_BIT] = priority_scheme_select;
				end
				`OFS_UPPER:  rd_val = upper_limit_reg;
				`OFS_LOWER:  rd_val = lower_limit_reg;
				`OFS_BUFFER: rd_val = transfer_buffer_reg;
				default:     rd_val = 16'h0000;
			endcase
		end else if (ch_hit) begin
			case (rsel)
				`OFS_CH_CTRL: rd_val = {5'h00, ctl_v[ch_sel*`CH_CTRL_W +: `CH_CTRL_W]};
				`OFS_CH_IRQ:  rd_val = {15'h0000, irq_v[ch_sel]};
				`OFS_CH_SRC:  rd_val = src_v[ch_sel*16 +: 16];
				`OFS_CH_DST:  rd_val = dst_v[ch_sel*16 +: 16];
				`OFS_CH_CNT:  rd_val = cnt_v[ch_sel*16 +: 16];
				default:      rd_val = 16'h0000;
			endcase
		end
	end

	// One wait state keeps the decode off the answer path
	always @(posedge mclk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~(mod_hit | ch_hit);
			if (psel && penable && !pready && !pwrite)
				prdata <= {16'h0000, rd_val};
		end
	end

	// Transfer sequencer
	always @(posedge mclk) begin
		if (!rst_n) begin
			state               <= S_IDLE;
			act                 <= 3'h0;
			last_grant          <= 3'h5;
			mem_req             <= 1'b0;
			mem_we              <= 1'b0;
			mem_byte            <= 1'b0;
			mem_addr            <= 16'h0000;
			mem_wdata           <= 16'h0000;
			transfer_buffer_reg <= 16'h0000;
		end else if (!engine_enable) begin
			state   <= S_IDLE;	// [R01]
			mem_req <= 1'b0;
			mem_we  <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (|req_v) begin
						act        <= pick(req_v, last_grant, priority_scheme_select);	// [R02]
						last_grant <= pick(req_v, last_grant, priority_scheme_select);
						state      <= S_LOAD;
					end
				end
				S_LOAD: state <= S_RD;
				S_RD: begin
					// Read only once the buffer has room
					if (!mem_req && f_in_ready) begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b0;
						mem_byte <= cur_ctl[`CH_SIZE_BIT];
						mem_addr <= cur_src;
					end else if (mem_req && mem_ack) begin
						mem_req             <= 1'b0;
						transfer_buffer_reg <= mem_rdata;
						state               <= S_WR;
					end
				end
				S_WR: begin
					if (!mem_req && f_out_valid) begin
						mem_req   <= 1'b1;
						mem_we    <= 1'b1;
						mem_addr  <= cur_dst;
						mem_wdata <= f_out_data;
					end else if (mem_req && mem_ack) begin
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						state   <= cur_ctl[`CH_NULL_WRITE_ENABLE_BIT] ? S_NW : S_NEXT;
					end
				end
				S_NW: begin
					// Dummy write back to the source for symmetric buffers
					if (!mem_req) begin
						mem_req  <= 1'b1;
						mem_we   <= 1'b1;
						mem_addr <= cur_src;
					end else if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						state   <= S_NEXT;
					end
				end
				S_NEXT: state <= fin ? S_IDLE : S_RD;
				default: state <= S_IDLE;
			endcase
		end
	end
endmodule // dma_engine_control_registers
`default_nettype wire

/* shared/dma_consts.vh */
// Offsets, field positions, reset values, address modes and step sizes of the DMA register block
// Operation
// R01: Engine enable at bit 15; clearing it stops the engine and aborts transfers.
// R02: Bit 0 picks round-robin (1) or fixed (0) channel priority.
// R03: Four module registers: control, upper limit, lower limit, transfer buffer.
// R04: Each channel has control, interrupt, source, destination and count registers.
// R05: Engine control bits 14 to 1 ignore writes and read as zero.
// R06: Both engine control bits clear at reset: disabled, fixed priority.
// R07: Source mode: 00 fixed, 01 increment, 10 decrement, 11 indirect unchanged.
// R08: Destination mode uses the same four codes on the destination address.
// R09: Reload set restores source, destination and count at next operation start.
// R10: Soft request starts a transfer; hardware clears it when that transfer completes.
// R11: Channel control field layout from bit 10 down to bit 0, all resetting to zero.
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH

`define NUM_CH          6
// Register indices within a block, decoded from address bits 4 to 2
`define OFS_ENG_CTRL    3'h0
`define OFS_UPPER       3'h1
`define OFS_LOWER       3'h2
`define OFS_BUFFER      3'h3
`define MOD_REGS        3'h4
`define OFS_CH_CTRL     3'h0
`define OFS_CH_IRQ      3'h1
`define OFS_CH_SRC      3'h2
`define OFS_CH_DST      3'h3
`define OFS_CH_CNT      3'h4
`define CH_REGS         3'h5
// Engine control fields
`define ENG_EN_BIT      15
`define ENG_RR_BIT      0
`define ENG_CTRL_RST    16'h0000
// Channel control fields
`define CH_NULL_WRITE_ENABLE_BIT    10
`define CH_RELOAD_BIT   9
`define CH_SREQ_BIT     8
`define CH_SMODE_HI     7
`define CH_SMODE_LO     6
`define CH_DMODE_HI     5
`define CH_DMODE_LO     4
`define CH_TRREP_BIT    3
`define CH_TRCONT_BIT   2
`define CH_SIZE_BIT     1
`define CH_EN_BIT       0
`define CH_CTRL_W       11
`define CH_CTRL_RST     11'h000
// Address modes
`define AM_FIXED        2'h0
`define AM_INC          2'h1
`define AM_DEC          2'h2
`define AM_INDIRECT     2'h3
// Step sizes
`define STEP_WORD       16'h0002
`define STEP_BYTE       16'h0001
// Buffer
`define FIFO_WIDTH      16
`define FIFO_DEPTH      16
`define FIFO_AW         4

`endif

/* src/word_fifo.v */
// Parameterised valid/ready FIFO held in flip-flops
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             rst_n,
	input  wire             flush,
	// Fill side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wptr;
	reg  [AW-1:0]    rptr;
	reg  [AW:0]      fill;
	wire             push;
	wire             pop;

	assign in_ready  = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign out_data  = mem[rptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge mclk) begin
		if (push)
			mem[wptr] <= in_data;
	end

	always @(posedge mclk) begin
		if (!rst_n || flush) begin
			wptr <= {AW{1'b0}};
			rptr <= {AW{1'b0}};
			fill <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
			if (pop)
				rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
			if (push && !pop)
				fill <= fill + 1'b1;
			else if (pop && !push)
				fill <= fill - 1'b1;
		end
	end
endmodule // word_fifo
`default_nettype wire

/* tb/dma_regs_checker_properties.sv */
// Port-level properties of the DMA register block
`timescale 1ns/1ns
`default_nettype none
module dma_regs_checker (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Memory port
	input wire logic        mem_req,
	input wire logic        mem_ack,
	input wire logic [15:0] mem_addr
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic eng_en;
	logic eng_rr;
	wire  done = psel && penable && pready;
	wire  ctl_wr = done && pwrite && paddr == 8'h00;
	wire  ctl_rd = done && !pwrite && paddr == 8'h00;
	// Shadow of the two writable engine bits
	always @(posedge mclk) begin
		if (!rst_n) begin
			eng_en <= 1'b0;
			eng_rr <= 1'b0;
		end else if (ctl_wr) begin
			eng_en <= pwdata[15];
			eng_rr <= pwdata[0];
		end
	end
	sequence s_wait_state;
		!pready ##1 pready;
	endsequence
	sequence s_released;
		##1 !mem_req;
	endsequence
	a_one_wait: assert property ($rose(penable) && psel |-> s_wait_state)
		else $error("answer not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_unmapped_err: assert property (done && paddr[7:4] == 4'h1 |-> pslverr)
		else $error("gap address not refused");
	a_mapped_ok: assert property (done && (paddr == 8'h00 || paddr == 8'h20) |-> !pslverr)
		else $error("mapped address refused");
	a_unused_zero: assert property (ctl_rd |-> prdata[14:1] == 14'h0 && prdata[31:16] == 16'h0)
		else $error("unused engine bits not zero");
	a_ctl_readback: assert property (ctl_rd |-> prdata[15] == eng_en && prdata[0] == eng_rr)
		else $error("engine control readback wrong");
	a_abort_req: assert property (ctl_wr && !pwdata[15] |-> ##[1:2] !mem_req)
		else $error("disable did not abort");
	a_off_idle: assert property ((!eng_en) [*3] |-> !mem_req)
		else $error("request while engine off");
	a_req_release: assert property (mem_req && mem_ack |-> s_released)
		else $error("request held after ack");
	a_req_hold: assert property (mem_req && !mem_ack && eng_en && !ctl_wr |=> mem_req && $stable(mem_addr))
		else $error("request dropped early");
endmodule // dma_regs_checker
`default_nettype wire

/* tb/data_space_model.sv */
// Data space responder for the DMA memory port
`timescale 1ns/1ns
`default_nettype none
module data_space_model (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        slow,
	// Memory port
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output var logic        mem_ack,
	output var logic [15:0] mem_rdata,
	// Last write seen
	output var logic [15:0] last_addr,
	output var logic [15:0] last_data
);
	logic [2:0] wait_cnt;
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0000;
	always @(posedge mclk) begin
		mem_ack <= 1'b0;
		// Data only valid with ack, toggles otherwise
		mem_rdata <= ~mem_rdata;
		if (!rst_n) begin
			wait_cnt <= 3'h0;
		end else if (mem_req && !mem_ack) begin
			if (wait_cnt == (slow ? 3'h6 : 3'h1)) begin
				mem_ack <= 1'b1;
				wait_cnt <= 3'h0;
				mem_rdata <= mem_addr ^ 16'hA5A5;
				if (mem_we) begin
					last_addr <= mem_addr;
					last_data <= mem_wdata;
				end
			end else begin
				wait_cnt <= wait_cnt + 3'h1;
			end
		end
	end
endmodule // data_space_model
`default_nettype wire

/* tb/dma_engine_control_registers_test.sv */
// Register-level testbench of the DMA register block
`timescale 1ns/1ns
`default_nettype none
module dma_engine_control_registers_test;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  hw_trigger;
	logic        mem_req;
	logic        mem_we;
	logic        mem_byte;
	logic        mem_ack;
	logic        slow;
	logic [15:0] mem_addr;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic [15:0] last_addr;
	logic [15:0] last_data;
	logic [31:0] rdv;
	logic        err;
	logic [15:0] st;
	logic [15:0] ctl;
	logic [15:0] exp_src;
	logic [1:0]  mm;
	logic [7:0]  regs [5] = '{8'h04, 8'h08, 8'hC8, 8'hCC, 8'hD0};
	int          error_cnt = 0;
	int          n_tests = 0;

	dma_engine_control_registers dma_engine_control_registers_i (.mclk, .rst_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hw_trigger,
		.mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	data_space_model data_space_model_i (.mclk, .rst_n, .slow, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .last_addr, .last_data);

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic wrap_up;
		if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; result left in rdv and err
	task automatic apb(input logic [7:0] a, input logic w, input logic [15:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge mclk);
		penable <= 1'b1;
		// No assumed latency; only the watchdog ends a missing answer
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		apb(a, 1'b0, 16'h0000);
		chk(rdv[15:0], e);
	endtask

	// Poll channel 0 done flag, then clear it
	task automatic wait_done;
		do begin
			apb(8'h24, 1'b0, 16'h0000);
		end while (rdv[0] !== 1'b1);
		chk({15'h0000, rdv[0]}, 16'h0001);
		apb(8'h24, 1'b1, 16'h0001);
	endtask

	task automatic start(input logic [15:0] c, input logic [15:0] k);
		apb(8'h28, 1'b1, 16'h0100);
		apb(8'h2C, 1'b1, 16'h0200);
		apb(8'h30, 1'b1, k);
		apb(8'h20, 1'b1, c);
	endtask

	// Wait for the next memory request; the watchdog ends a hang
	task automatic wait_req;
		while (mem_req !== 1'b1) @(posedge mclk);
	endtask

	initial begin
		#(50 * 20000);
		error_cnt++;
		wrap_up;
	end

	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		hw_trigger = 6'h00;
		slow = 1'b0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk(8'h00, 16'h0000);
		rdchk(8'h20, 16'h0000);
		apb(8'h00, 1'b1, 16'hFFFF);
		rdchk(8'h00, 16'h8001);
		apb(8'h10, 1'b0, 16'h0000);
		chk({15'h0000, err}, 16'h0001);
		for (int i = 0; i < 5; i++) begin
			apb(regs[i], 1'b1, 16'h1230 + 16'(i));
			rdchk(regs[i], 16'h1230 + 16'(i));
		end
		for (int m = 0; m < 4; m++) begin
			mm = m[1:0];
			st = mm[1] ? 16'h0001 : 16'h0002;
			ctl = {7'h00, 1'b1, mm, mm, 2'h0, mm[1], 1'b1};
			start(ctl, 16'h0001);
			wait_req;
			chk({15'h0000, mem_byte}, {15'h0000, mm[1]});
			wait_done;
			exp_src = (mm == 2'h1) ? 16'h0100 + st : (mm == 2'h2) ? 16'h0100 - st : 16'h0100;
			rdchk(8'h28, exp_src);
			rdchk(8'h2C, exp_src + 16'h0100);
			rdchk(8'h20, ctl & 16'hFEFE);
			rdchk(8'h0C, 16'hA4A5);
			chk(last_addr, 16'h0200);
			if (!mm[1]) chk(last_data, 16'hA4A5);
		end
		start(16'h0351, 16'h0001);
		wait_done;
		apb(8'h20, 1'b1, 16'h0251);
		@(posedge mclk);
		hw_trigger <= 6'h01;
		@(posedge mclk);
		hw_trigger <= 6'h00;
		wait_done;
		rdchk(8'h28, 16'h0102);
		// Continuous block of two words, dummy write after each
		start(16'h0555, 16'h0002);
		wait_done;
		rdchk(8'h28, 16'h0104);
		rdchk(8'h2C, 16'h0204);
		rdchk(8'h30, 16'h0000);
		rdchk(8'h20, 16'h0454);
		rdchk(8'h0C, 16'hA4A7);
		chk(last_addr, 16'h0102);
		chk(last_data, 16'hA4A7);
		slow <= 1'b1;
		start(16'h0151, 16'h0001);
		wait_req;
		apb(8'h00, 1'b1, 16'h0001);
		repeat (2) @(posedge mclk);
		chk({15'h0000, mem_req}, 16'h0000);
		rdchk(8'h00, 16'h0001);
		// Channel 0 still pending; round-robin would now serve channel 1
		apb(8'h48, 1'b1, 16'h0300);
		apb(8'h40, 1'b1, 16'h0101);
		apb(8'h00, 1'b1, 16'h8000);
		wait_req;
		chk(mem_addr, 16'h0100);
		wrap_up;
	end
endmodule // dma_engine_control_registers_test

bind dma_engine_control_registers dma_regs_checker dma_regs_checker_i (.mclk, .rst_n,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req,
	.mem_ack, .mem_addr);
`default_nettype wire
